// ===== hw/cdso_pkg.sv
// Constants and types for the compute data serial output port
// Functional notes
// - Enable bit turns segment pins 3, 4, 5 into serial clock, data, frame.
// - Segment pin 6 is ready output only when ready enable and enable both set.
// - With serial enabled, pins 3, 4, 5 serve the port regardless of display settings.
// - Serial clock is 5 MHz with fast select low, 10 MHz with it high.
// - Clock gating low keeps the serial clock toggling continuously.
// - Clock gating high holds serial clock low whenever no bits shift.
// - Frame interval 0 pulses once per block; 1, 2, 3 every 8, 16, 32 bits.
// - Frame polarity 0 gives active-high pulse, 1 gives active-low pulse.
// - Ready polarity 0 gives active-high ready, 1 gives active-low ready.
// - Enabled port sends data-memory words from start address through end address.
package cdso_pkg;

   // Register map, byte addresses on the register port
   localparam logic [15:0] ADDR_CONTROL = 16'h2070;
   localparam logic [15:0] ADDR_START   = 16'h2071;
   localparam logic [15:0] ADDR_END     = 16'h2072;
   localparam logic [15:0] ADDR_STATUS  = 16'h2073;

   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] START_RESET   = 8'h00;
   localparam logic [7:0] END_RESET     = 8'h00;

   // Control field positions
   localparam int BIT_ENABLE     = 7;
   localparam int BIT_FAST_CLOCK = 6;
   localparam int BIT_CLOCK_GATE = 5;
   localparam int BIT_FRAME_HI   = 4;
   localparam int BIT_FRAME_LO   = 3;
   localparam int BIT_FRAME_POL  = 2;
   localparam int BIT_READY_EN   = 1;
   localparam int BIT_READY_POL  = 0;

   // Status field positions
   localparam int STAT_BUSY  = 0;
   localparam int STAT_SHIFT = 1;

   // Frame interval codes
   localparam logic [1:0] FRAME_BLOCK = 2'h0;
   localparam logic [1:0] FRAME_8     = 2'h1;
   localparam logic [1:0] FRAME_16    = 2'h2;
   localparam logic [1:0] FRAME_32    = 2'h3;

   // Serial clock timing from the system clock rate
   localparam int SYS_CLK_KHZ     = 250000;
   localparam int SCLK_SLOW_KHZ   = 5000;
   localparam int SCLK_FAST_KHZ   = 10000;
   localparam int SLOW_PERIOD_CYC = SYS_CLK_KHZ / SCLK_SLOW_KHZ;
   localparam int FAST_PERIOD_CYC = SYS_CLK_KHZ / SCLK_FAST_KHZ;
   // Low phase takes the odd cycle so the high phase never exceeds half
   localparam int SLOW_LOW_CYC    = (SLOW_PERIOD_CYC + 1) / 2;
   localparam int FAST_LOW_CYC    = (FAST_PERIOD_CYC + 1) / 2;
   localparam int DIV_W           = 7;

   // Data memory geometry
   localparam int WORD_W = 32;
   localparam int ADDR_W = 8;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOAD,
      ST_ARMED,
      ST_SHIFT
   } cdso_state_t;

endpackage : cdso_pkg

// ===== hw/cdso_serial_out.sv
// Compute data serial output port: registers, clock divider, shifter, pin mux
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module cdso_serial_out
   import cdso_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // Register port
   input  wire logic [15:0]       regAddr,
   input  wire logic [7:0]        regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [7:0]        regRdata,
   // Block start from the compute engine, one-cycle pulse
   input  wire logic              blockStart,
   // Data memory read port, data one cycle after the address
   output logic      [ADDR_W-1:0] memAddr,
   output logic                   memRdEn,
   input  wire logic [WORD_W-1:0] memData,
   // Display driver levels for segment pins 3 to 6
   input  wire logic [3:0]        displaySeg,
   // Shared segment pins 3 to 6
   output logic [3:0]             segPin
);

   typedef struct packed {
      logic [7:0]        control;
      logic [7:0]        startAddr;
      logic [7:0]        endAddr;
      logic [7:0]        rdata;
      cdso_state_t       state;
      logic [DIV_W-1:0]  divCnt;
      logic              sclk;
      logic              sdata;
      logic              frame;
      logic              ready;
      logic [WORD_W-1:0] shiftReg;
      logic [WORD_W-1:0] nextWord;
      logic [4:0]        bitIdx;
      logic [ADDR_W-1:0] wordAddr;
      logic [ADDR_W-1:0] memAddr;
      logic              memRdEn;
      logic              fetchFirst;
      logic              fetchNext;
      logic              capFirst;
      logic              capNext;
      logic [3:0]        pins;
   } cdso_regs_t;

   cdso_regs_t r_q;
   cdso_regs_t r_d;

   // Memory read timeline: read strobe in cycle n, data on memData in n+1,
   // captured into the shifter at the end of n+1. Words are fetched one
   // word ahead, so each read has a full word time of slack.

   // Frame boundary for the current interval code
   function automatic logic frameStart(input logic [1:0] code, input logic [4:0] idx,
                                       input logic firstOfBlock);
      logic hit;
      hit = 1'b0;
      unique case (code)
         // Code 0 ignores the bit index; only the first bit of a block qualifies
         FRAME_BLOCK: hit = firstOfBlock;
         FRAME_8:     hit = (idx[2:0] == 3'h0);
         FRAME_16:    hit = (idx[3:0] == 4'h0);
         FRAME_32:    hit = (idx == 5'h00);
      endcase
      return hit;
   endfunction : frameStart

   // Pin levels for an asserted or idle strobe of a given polarity
   function automatic logic polarLevel(input logic active, input logic invert);
      return active ^ invert;
   endfunction : polarLevel

   logic              enable;
   logic              fastClk;
   logic              gateClk;
   logic [1:0]        frameCode;
   logic              framePol;
   logic              readyEn;
   logic              readyPol;
   logic [DIV_W-1:0]  periodCyc;
   logic [DIV_W-1:0]  lowCyc;
   logic              boundary;
   logic [DIV_W-1:0]  divNext;

   // Control field decode
   always_comb
   begin
      enable    = r_q.control[BIT_ENABLE];
      fastClk   = r_q.control[BIT_FAST_CLOCK];
      gateClk   = r_q.control[BIT_CLOCK_GATE];
      frameCode = r_q.control[BIT_FRAME_HI:BIT_FRAME_LO];
      framePol  = r_q.control[BIT_FRAME_POL];
      readyEn   = r_q.control[BIT_READY_EN];
      readyPol  = r_q.control[BIT_READY_POL];
      periodCyc = fastClk ? DIV_W'(FAST_PERIOD_CYC) : DIV_W'(SLOW_PERIOD_CYC);
      lowCyc    = fastClk ? DIV_W'(FAST_LOW_CYC) : DIV_W'(SLOW_LOW_CYC);
      // Compare with >= so a switch to the faster rate cannot overrun the count
      boundary  = (r_q.divCnt >= periodCyc - DIV_W'(1));
      divNext   = boundary ? '0 : r_q.divCnt + DIV_W'(1);
   end

   // Next-state logic for registers, divider, shifter and pins
   always_comb
   begin
      r_d         = r_q;
      r_d.memRdEn    = 1'b0;
      r_d.fetchFirst = 1'b0;
      r_d.fetchNext  = 1'b0;

      // Capture strobes trail each read by one cycle to match the memory latency
      r_d.capFirst   = r_q.fetchFirst;
      r_d.capNext    = r_q.fetchNext;

      // Register writes
      // Status address is read only; writes there fall to the default arm
      if (regWr)
      begin
         unique case (regAddr)
            ADDR_CONTROL: r_d.control   = regWdata;
            ADDR_START:   r_d.startAddr = regWdata;
            ADDR_END:     r_d.endAddr   = regWdata;
            default:      ;
         endcase
      end

      // Register reads, data valid only in the following cycle
      r_d.rdata = 8'h00;
      if (regRd)
      begin
         unique case (regAddr)
            ADDR_CONTROL: r_d.rdata = r_q.control;
            ADDR_START:   r_d.rdata = r_q.startAddr;
            ADDR_END:     r_d.rdata = r_q.endAddr;
            // Status bits are derived live; nothing sticky to clear
            ADDR_STATUS:
            begin
               r_d.rdata[STAT_BUSY]  = (r_q.state != ST_IDLE);
               r_d.rdata[STAT_SHIFT] = (r_q.state == ST_SHIFT);
            end
            default:      r_d.rdata = 8'h00;
         endcase
      end

      // Free-running divider; sets the serial bit period
      r_d.divCnt = divNext;

      // Memory data capture in the cycle the read data stands
      if (r_q.capFirst)
         r_d.shiftReg = memData;
      if (r_q.capNext)
         r_d.nextWord = memData;

      // Transfer sequencing
      unique case (r_q.state)
         ST_IDLE:
         begin
            // A start pulse while busy or disabled is simply dropped
            if (enable && blockStart)
            begin
               r_d.memAddr    = r_q.startAddr;
               r_d.memRdEn    = 1'b1;
               r_d.fetchFirst = 1'b1;
               r_d.wordAddr = r_q.startAddr;
               r_d.state    = ST_LOAD;
            end
         end
         ST_LOAD:
         begin
            // Arm only once the first word lands; arming earlier sends a stale word
            if (r_q.capFirst)
            begin
               r_d.state = ST_ARMED;
               r_d.ready = 1'b1;
            end
         end
         ST_ARMED:
         begin
            if (boundary)
            begin
               // First bit goes out on the falling edge that starts the period
               r_d.sdata    = r_q.shiftReg[WORD_W-1];
               r_d.shiftReg = r_q.shiftReg << 1;
               r_d.bitIdx   = 5'h00;
               r_d.frame    = frameStart(frameCode, 5'h00, 1'b1);
               r_d.state    = ST_SHIFT;
               // Fetch the second word while the first one shifts
               if (r_q.wordAddr != r_q.endAddr)
               begin
                  r_d.memAddr   = r_q.wordAddr + ADDR_W'(1);
                  r_d.memRdEn   = 1'b1;
                  r_d.fetchNext = 1'b1;
               end
            end
         end
         ST_SHIFT:
         begin
            if (boundary)
            begin
               // Word boundary: finish the block or swap in the prefetched word
               if (r_q.bitIdx == 5'h1F)
               begin
                  if (r_q.wordAddr == r_q.endAddr)
                  begin
                     // Whole block sent; lines go quiet
                     r_d.state = ST_IDLE;
                     r_d.sdata = 1'b0;
                     r_d.frame = 1'b0;
                     r_d.ready = 1'b0;
                  end
                  else
                  begin
                     r_d.sdata    = r_q.nextWord[WORD_W-1];
                     r_d.shiftReg = r_q.nextWord << 1;
                     r_d.bitIdx   = 5'h00;
                     r_d.wordAddr = r_q.wordAddr + ADDR_W'(1);
                     r_d.frame    = frameStart(frameCode, 5'h00, 1'b0);
                     // Prefetch the word after next while this one shifts
                     if (r_q.wordAddr + ADDR_W'(1) != r_q.endAddr)
                     begin
                        r_d.memAddr   = r_q.wordAddr + ADDR_W'(2);
                        r_d.memRdEn   = 1'b1;
                        r_d.fetchNext = 1'b1;
                     end
                  end
               end
               else
               begin
                  // Mid-word: next bit out, most significant first
                  r_d.sdata    = r_q.shiftReg[WORD_W-1];
                  r_d.shiftReg = r_q.shiftReg << 1;
                  r_d.bitIdx   = r_q.bitIdx + 5'h01;
                  r_d.frame    = frameStart(frameCode, r_q.bitIdx + 5'h01, 1'b0);
               end
            end
         end
      endcase

      // Disabling the port aborts any block in progress
      // A fetch still in flight only refills the shifter or nextWord; the next start reloads them
      if (!enable)
      begin
         r_d.state = ST_IDLE;
         r_d.sdata = 1'b0;
         r_d.frame = 1'b0;
         r_d.ready = 1'b0;
      end

      // Serial clock: low in the first part of each period, high in the rest
      // Gating looks at the next state so the clock stops on the same edge
      if (gateClk && r_d.state != ST_SHIFT)
         r_d.sclk = 1'b0;
      else
         r_d.sclk = (divNext >= lowCyc);

      // Shared pin mux, serial function wins over display settings
      if (enable)
      begin
         r_d.pins[0] = r_q.sclk;
         r_d.pins[1] = r_q.sdata;
         r_d.pins[2] = polarLevel(r_q.frame, framePol);
      end
      else
      begin
         r_d.pins[2:0] = displaySeg[2:0];
      end

      // Ready pin needs both enables; otherwise the display keeps segment pin 6
      if (enable && readyEn)
         r_d.pins[3] = polarLevel(r_q.ready, readyPol);
      else
         r_d.pins[3] = displaySeg[3];
   end

   // State register, synchronous reset
   // Pins sit low during reset; display levels return one cycle after release
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         r_q           <= '0;
         r_q.control   <= CONTROL_RESET;
         r_q.startAddr <= START_RESET;
         r_q.endAddr   <= END_RESET;
         r_q.state     <= ST_IDLE;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // Outputs straight from flops
   // No logic after the flops, so the shared pins switch without glitches
   assign regRdata = r_q.rdata;
   assign memAddr  = r_q.memAddr;
   assign memRdEn  = r_q.memRdEn;
   assign segPin   = r_q.pins;

endmodule : cdso_serial_out

// ===== tb/cdso_rx_model.sv
// Receiver at the far end of the serial link, records bits and frame flags
`timescale 1ns/1ps
module cdso_rx_model
(
   // Serial link, levels already corrected for polarity
   input wire logic sclk,
   input wire logic sdata,
   input wire logic frameAct,
   input wire logic readyAct
);
   logic rxBits[$];
   logic rxFrames[$];
   logic inBlock = 1'b0;
   // Sample mid-bit on the rising edge from the first framed bit while ready;
   // a free-running clock also rises in the ready window before the first bit
   always @(posedge sclk)
   begin
      if (!readyAct)
         inBlock = 1'b0;
      else if (inBlock || frameAct)
      begin
         inBlock = 1'b1;
         rxBits.push_back(sdata);
         rxFrames.push_back(frameAct);
      end
   end
endmodule : cdso_rx_model

// ===== tb/cdso_serial_out_sva.sv
// Assertions on the serial output port pins and register port
`timescale 1ns/1ps
module cdso_serial_out_sva
   import cdso_pkg::*;
(
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              rstn,
   // Register port
   input wire logic [15:0]       regAddr,
   input wire logic [7:0]        regWdata,
   input wire logic              regWr,
   input wire logic              regRd,
   input wire logic [7:0]        regRdata,
   // Memory side and pins
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic              memRdEn,
   input wire logic [3:0]        displaySeg,
   input wire logic [3:0]        segPin
);
   logic [7:0] ctrl_q, start_q, end_q;
   logic [5:0] hi_q, lo_q, act_q, age_q;
   logic       en, fast, frameAct;
   assign en = ctrl_q[BIT_ENABLE] && age_q == 6'h3F;
   assign fast = ctrl_q[BIT_FAST_CLOCK];
   assign frameAct = segPin[2] ^ ctrl_q[BIT_FRAME_POL];
   // Shadows and phase counters; age holds checks off after a reconfigure
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         ctrl_q <= 8'h00;
         start_q <= 8'h00;
         end_q <= 8'h00;
         age_q <= 6'h00;
      end
      else if (regWr && regAddr == ADDR_CONTROL)
      begin
         ctrl_q <= regWdata;
         age_q <= 6'h00;
      end
      else
      begin
         if (regWr && regAddr == ADDR_START)
            start_q <= regWdata;
         if (regWr && regAddr == ADDR_END)
            end_q <= regWdata;
         if (age_q != 6'h3F)
            age_q <= age_q + 6'h01;
      end
      hi_q <= segPin[0] ? hi_q + 6'h01 : 6'h00;
      lo_q <= segPin[0] ? 6'h00 : lo_q + 6'h01;
      act_q <= frameAct ? act_q + 6'h01 : 6'h00;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   property p_rd_regs;
      regRd && regAddr inside {[ADDR_CONTROL:ADDR_END]}
         |=> regRdata == $past(regAddr[1] ? end_q : regAddr[0] ? start_q : ctrl_q);
   endproperty
   a_rd_regs: assert property (p_rd_regs) else $error("register read wrong");
   property p_rd_zero;
      !(regRd && regAddr inside {[ADDR_CONTROL:ADDR_STATUS]}) |=> regRdata == 8'h00;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
   property p_pins_display;
      $past(rstn) && !$past(ctrl_q[BIT_ENABLE]) |-> segPin[2:0] == $past(displaySeg[2:0]);
   endproperty
   a_pins_display: assert property (p_pins_display) else $error("pins not display");
   property p_ready_display;
      $past(rstn) && !($past(ctrl_q[BIT_ENABLE]) && $past(ctrl_q[BIT_READY_EN]))
         |-> segPin[3] == $past(displaySeg[3]);
   endproperty
   a_ready_display: assert property (p_ready_display) else $error("pin 6 wrong");
   property p_mem_range;
      memRdEn |-> memAddr >= start_q && memAddr <= end_q;
   endproperty
   a_mem_range: assert property (p_mem_range) else $error("read outside region");
   property p_clk_half;
      en && !ctrl_q[BIT_CLOCK_GATE] && $fell(segPin[0]) |-> hi_q == (fast ? 6'd12 : 6'd25);
   endproperty
   a_clk_half: assert property (p_clk_half) else $error("clock high phase wrong");
   property p_clk_run;
      en && !ctrl_q[BIT_CLOCK_GATE] |-> lo_q <= (fast ? 6'd13 : 6'd25);
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clock stopped");
   property p_clk_gated;
      en && ctrl_q[BIT_CLOCK_GATE] && ctrl_q[BIT_READY_EN] && segPin[3] == ctrl_q[BIT_READY_POL]
         && $past(segPin[3]) == ctrl_q[BIT_READY_POL] |-> !segPin[0];
   endproperty
   a_clk_gated: assert property (p_clk_gated) else $error("gated clock ran");
   property p_frame_len;
      en && $fell(frameAct) |-> act_q == (fast ? 6'd25 : 6'd50);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
endmodule : cdso_serial_out_sva

// ===== tb/cdso_serial_out_tb.sv
// Self-checking bench for the serial output port
`timescale 1ns/1ps
module cdso_serial_out_tb
   import cdso_pkg::*;
;
   logic        clk_sys = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, blockStart = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0]  regWdata = 8'h00, regRdata, memAddr, ctrl = 8'h00;
   logic [31:0] memData = 32'h0, mem [256];
   logic [3:0]  displaySeg = 4'h0, segPin, d;
   logic        memRdEn;
   int          errors = 0, checked = 0, s, n, t;
   cdso_serial_out i_cdso_serial_out (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .blockStart(blockStart), .memAddr(memAddr), .memRdEn(memRdEn), .memData(memData),
      .displaySeg(displaySeg), .segPin(segPin));
   cdso_rx_model i_cdso_rx_model (.sclk(segPin[0]), .sdata(segPin[1]),
      .frameAct(segPin[2] ^ ctrl[BIT_FRAME_POL]), .readyAct(segPin[3] ^ ctrl[BIT_READY_POL]));
   always #2 clk_sys = ~clk_sys;
   // Data memory with one cycle latency, display levels wander
   always @(posedge clk_sys)
   begin
      if (memRdEn)
         memData <= mem[memAddr];
      displaySeg <= 4'($urandom);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      chk({24'h0, regRdata}, {24'h0, exp});
   endtask : rd
   function automatic logic frameExp(input int i, input logic [1:0] fi);
      return (fi == FRAME_BLOCK) ? (i == 0) : (i % (4 << fi) == 0);
   endfunction : frameExp
   task automatic conclude;
      if (errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // Hang guard well beyond eight blocks at the slow rate
   initial
   begin
      #300000;
      errors++;
      conclude();
   end
   initial
   begin
      void'($urandom(32'h0A3B4E40));
      foreach (mem[i])
         mem[i] = $urandom;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(ADDR_CONTROL, CONTROL_RESET);
      rd(ADDR_START, START_RESET);
      rd(ADDR_END, END_RESET);
      rd(16'h2074, 8'h00);
      // Blocks under every frame interval, rate, gating and polarities random
      for (int k = 0; k < 8; k++)
      begin
         ctrl = {1'b1, 2'($urandom), 2'(k), 1'($urandom), 1'b1, 1'($urandom)};
         s = $urandom_range(200);
         n = 2 + k % 2;
         wr(ADDR_CONTROL, ctrl);
         wr(ADDR_START, 8'(s));
         wr(ADDR_END, 8'(s + n - 1));
         rd(ADDR_CONTROL, ctrl);
         i_cdso_rx_model.rxBits.delete();
         i_cdso_rx_model.rxFrames.delete();
         repeat (70) @(posedge clk_sys);
         blockStart <= 1'b1;
         @(posedge clk_sys);
         blockStart <= 1'b0;
         for (t = 0; t < 200 && (segPin[3] ^ ctrl[BIT_READY_POL]) !== 1'b1; t++)
            @(posedge clk_sys);
         repeat (60) @(posedge clk_sys);
         rd(ADDR_STATUS, 8'((1 << STAT_BUSY) | (1 << STAT_SHIFT)));
         for (t = 0; t < 6000 && (segPin[3] ^ ctrl[BIT_READY_POL]) !== 1'b0; t++)
            @(posedge clk_sys);
         rd(ADDR_STATUS, 8'h00);
         chk(i_cdso_rx_model.rxBits.size(), 32 * n);
         for (int b = 0; b < 32 * n; b++)
         begin
            chk(i_cdso_rx_model.rxBits[b], mem[8'(s + b / 32)][31 - b % 32]);
            chk(i_cdso_rx_model.rxFrames[b], frameExp(b, 2'(k)));
         end
      end
      // Enabled without the ready pin, then back to display duty
      wr(ADDR_CONTROL, 8'h80);
      repeat (100) @(posedge clk_sys);
      ctrl = 8'h00;
      wr(ADDR_CONTROL, ctrl);
      repeat (4) @(posedge clk_sys);
      #1;
      d = displaySeg;
      @(posedge clk_sys);
      #1;
      chk({28'h0, segPin}, {28'h0, d});
      conclude();
   end
endmodule : cdso_serial_out_tb
bind cdso_serial_out cdso_serial_out_sva i_cdso_serial_out_sva (.clk_sys, .rstn, .regAddr,
   .regWdata, .regWr, .regRd, .regRdata, .memAddr, .memRdEn, .displaySeg, .segPin);
